// ===== design/rcw_top.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rcw_cfg.svh"
module rcw_top
  import rcw_pkg::*;
(
  // Clock and reset (rst_n is the power-on domain reset)
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Configuration straps, static
  input wire logic [1:0] brownout_cfg_mode,
  input wire logic [1:0] wd_mode_cfg,
  input wire logic wd_cfg_clock_select,
  // Reset causes, events and status levels from other clock domains
  input wire logic brownout_event,
  input wire logic ext_reset_pin_event,
  input wire logic reset_instr_event,
  input wire logic stack_overflow_event,
  input wire logic stack_underflow_event,
  input wire logic brownout_circuit_ready,
  input wire logic sleep,
  input wire logic wd_clear_instr,
  input wire logic low_freq_osc,
  input wire logic mid_freq_osc,
  // Outputs
  output logic brownout_reset_enable,
  output logic wd_active,
  output logic wd_low_freq_osc_en,
  output logic wd_mid_freq_osc_en,
  output logic device_reset_req
);
  localparam int NSYNC = 10;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    rcw_cause_type cause;
    logic sw_brownout_enable;
    logic brownout_ready;
    logic wd_sw_enable;
    logic [2:0] wd_reg_clock_select;
    logic [4:0] wd_prescale;
    logic [2:0] wd_window;
    logic wd_arm;
    logic first;
    rcw_bus_type bus;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic bor_en;
    logic wd_act;
    logic lf_en;
    logic mf_en;
    logic rst_req;
  } rcw_state_type;

  rcw_state_type state;
  rcw_state_type next_state;
  logic wd_timeout;
  logic wd_violation;
  logic [4:0] wd_top;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sy;
  logic [NSYNC-1:0] rise;
  logic tick;
  logic wd_run;
  logic wr_hit;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  assign raw_in = {mid_freq_osc, low_freq_osc, wd_clear_instr, sleep, brownout_circuit_ready,
    stack_underflow_event, stack_overflow_event, reset_instr_event, ext_reset_pin_event,
    brownout_event};
  assign sy = state.s2;
  assign rise = state.s2 & ~state.s3;

  function automatic logic [31:0] word_of(input logic [7:0] b);
    word_of = {24'h00_0000, b};
  endfunction

  function automatic logic lane_wr(input logic [3:0] be, input logic [13:0] a);
    lane_wr = be[0] && (avs_address == a);
  endfunction

  // ==========================================================
  // Watchdog mode and clock source
  // ==========================================================
  always_comb begin
    case (wd_mode_cfg)
      `RCW_WD_ON: wd_run = 1'b1;
      `RCW_WD_AWAKE: wd_run = !sy[6];
      `RCW_WD_SW: wd_run = state.wd_sw_enable;
      `RCW_WD_OFF: wd_run = 1'b0;
      default: wd_run = 1'b0;
    endcase
  end

  // Tick from whichever slow oscillator is enabled
  assign tick = (state.lf_en && rise[8]) || (state.mf_en && rise[9]);

  rcw_wd_core u_wd (
    .clk(clk),
    .rst_n(rst_n),
    .run(wd_run),
    .tick(tick),
    .clear(rise[7]),
    .arm(state.wd_arm),
    .prescale(state.wd_prescale),
    .window(state.wd_window),
    .timeout(wd_timeout),
    .violation(wd_violation),
    .top_bits(wd_top)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_state = state;
    next_state.s1 = raw_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    next_state.first = 1'b0;
    next_state.wd_arm = 1'b0;
    next_state.rst_req = 1'b0;
    wr_hit = 1'b0;

    // Enable follows software bit only in software brown-out mode
    next_state.bor_en = (brownout_cfg_mode == `RCW_BOR_MODE_SW) ? state.sw_brownout_enable :
      brownout_cfg_mode[1];
    // Ready only when the circuit is enabled and has warmed up
    next_state.brownout_ready = sy[5] && state.bor_en;
    next_state.wd_act = wd_run;
    if (wd_mode_cfg[1]) begin
      next_state.lf_en = wd_run && !wd_cfg_clock_select;
      next_state.mf_en = wd_run && wd_cfg_clock_select;
    end else begin
      next_state.lf_en = wd_run && (state.wd_reg_clock_select == 3'h0);
      next_state.mf_en = wd_run && (state.wd_reg_clock_select == 3'h1);
    end

    // Bus: one wait cycle, then acknowledge
    case (state.bus)
      RCW_IDLE: begin
        if (avs_read || avs_write) begin
          next_state.bus = RCW_ACK;
          next_state.resp = 2'h0;
          next_state.rdata = 32'h0000_0000;
          case (avs_address)
            `RCW_IDX_BORCTL: next_state.rdata = word_of({state.sw_brownout_enable, 6'h00,
              state.brownout_ready});
            `RCW_IDX_CAUSE: next_state.rdata = word_of(state.cause);
            `RCW_IDX_WDCTL: begin
              next_state.rdata = {18'h0_0000, state.wd_window, state.wd_reg_clock_select,
                2'h0, state.wd_prescale, state.wd_sw_enable};
              // Reading arms the next window clear
              next_state.wd_arm = avs_read;
            end
            `RCW_IDX_WDSTAT: next_state.rdata = {25'h000_0000, wd_top, wd_run, 1'b0};
            default: next_state.resp = 2'h2;
          endcase
          if (avs_write) begin
            next_state.rdata = 32'h0000_0000;
            wr_hit = 1'b1;
          end
        end
      end
      RCW_ACK: next_state.bus = RCW_IDLE;
      default: next_state.bus = RCW_IDLE;
    endcase

    if (wr_hit) begin
      if (lane_wr(avs_byteenable, `RCW_IDX_BORCTL)) begin
        next_state.sw_brownout_enable = avs_writedata[`RCW_BIT_SW_BROWNOUT_ENABLE];
      end
      if (lane_wr(avs_byteenable, `RCW_IDX_CAUSE)) begin
        // Plain store: no write ever requests a reset
        next_state.cause = rcw_cause_type'(avs_writedata[7:0]);
      end
      if (lane_wr(avs_byteenable, `RCW_IDX_WDCTL)) begin
        next_state.wd_sw_enable = avs_writedata[`RCW_BIT_SEN];
        next_state.wd_prescale = avs_writedata[`RCW_WDPS_LSB +: 5];
      end
      if (avs_byteenable[1] && avs_address == `RCW_IDX_WDCTL) begin
        next_state.wd_reg_clock_select = avs_writedata[`RCW_WDCS_LSB +: 3];
        next_state.wd_window = avs_writedata[`RCW_WIN_LSB +: 3];
      end
    end

    // Hardware cause updates win over a same-cycle write
    if (rise[3]) next_state.cause.stack_overflow = 1'b1;
    if (rise[4]) next_state.cause.stack_underflow = 1'b1;
    if (wd_violation) next_state.cause.wd_window_violation = 1'b0;
    if (wd_timeout && !sy[6]) next_state.cause.wd_timeout = 1'b0;
    if (rise[1]) next_state.cause.ext_reset_pin = 1'b0;
    if (rise[2]) next_state.cause.reset_instr = 1'b0;
    if (rise[0]) begin
      // Brown-out presets the cause flags and the software enable like power-on, but keeps power-on flag
      next_state.cause = rcw_cause_type'(`RCW_CAUSE_POR);
      next_state.cause.power_on = state.cause.power_on;
      next_state.cause.brownout = 1'b0;
      next_state.sw_brownout_enable = 1'b1;
    end
    if (wd_violation || (wd_timeout && !sy[6]) || rise[3] || rise[4]) begin
      next_state.rst_req = 1'b1;
    end

    // Power-on: first cycle after rst_n release marks power-on cause
    if (state.first) begin
      next_state.cause.power_on = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
      state.cause <= rcw_cause_type'(`RCW_CAUSE_POR);
      state.sw_brownout_enable <= 1'b1;
      state.wd_prescale <= `RCW_WDPS_RST;
      state.wd_window <= `RCW_WIN_RST;
      state.first <= 1'b1;
      state.bus <= RCW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign avs_readdata = state.rdata;
  assign avs_waitrequest = (state.bus != RCW_ACK);
  assign avs_response = state.resp;
  assign brownout_reset_enable = state.bor_en;
  assign wd_active = state.wd_act;
  assign wd_low_freq_osc_en = state.lf_en;
  assign wd_mid_freq_osc_en = state.mf_en;
  assign device_reset_req = state.rst_req;
endmodule

// ===== design/rcw_wd_core.sv
`timescale 1ns/1ps
// Window watchdog counter on the slow tick; tick frequency set outside.
module rcw_wd_core
  import rcw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  input wire logic arm,
  input wire logic [4:0] prescale,
  input wire logic [2:0] window,
  // Results
  output logic timeout,
  output logic violation,
  output logic [4:0] top_bits
);
  typedef struct packed {
    logic [27:0] count;
    logic armed;
    logic timeout;
    logic violation;
  } rcw_wd_state_type;

  rcw_wd_state_type state;
  rcw_wd_state_type next_state;
  logic [4:0] ps;
  logic [27:0] limit;
  logic [4:0] top;
  logic open_win;

  always_comb begin
    ps = (prescale > `RCW_WDPS_MAX) ? 5'h00 : prescale;
    // Period of 2^(ps+5) ticks: 1 ms steps up to 256 s on a 31 kHz tick
    limit = 28'h000_0001 << (ps + 5'h05);
    top = 5'(state.count >> (ps + 5'h00));
    // Window open when the top bits pass the closed fraction
    open_win = ({2'h0, top[4:2]} >= 5'(3'h7 - window));
    next_state = state;
    next_state.timeout = 1'b0;
    next_state.violation = 1'b0;
    if (!run) begin
      next_state.count = 28'h000_0000;
      next_state.armed = 1'b0;
    end else begin
      if (arm) begin
        next_state.armed = 1'b1;
      end
      if (clear) begin
        // Clear outside the window or when not armed is a violation; the count restarts either way
        if (!open_win || !state.armed) begin
          next_state.violation = 1'b1;
        end
        next_state.count = 28'h000_0000;
        next_state.armed = 1'b0;
      end else if (tick) begin
        if (state.count + 28'h000_0001 >= limit) begin
          next_state.timeout = 1'b1;
          next_state.count = 28'h000_0000;
        end else begin
          next_state.count = state.count + 28'h000_0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign timeout = state.timeout;
  assign violation = state.violation;
  assign top_bits = top;
endmodule

// ===== include/rcw_cfg.svh
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH
// Register byte addresses (printed offset 0x0FD7 is not word aligned)
`define RCW_ADDR_BORCTL 12'h0EE0
`define RCW_ADDR_CAUSE 12'h0FD7
`define RCW_ADDR_WDCTL 12'h0F00
`define RCW_ADDR_WDSTAT 12'h0F04
// Offset 0x0FD7 is not a multiple of four: the address port takes the offsets as indices, WDSTAT at 0x0F01
`define RCW_IDX_BORCTL 14'h0EE0
`define RCW_IDX_CAUSE 14'h0FD7
`define RCW_IDX_WDCTL 14'h0F00
`define RCW_IDX_WDSTAT 14'h0F01
// Field positions
`define RCW_BIT_SW_BROWNOUT_ENABLE 7
`define RCW_BIT_BRDY 0
`define RCW_BIT_SEN 0
`define RCW_WDPS_LSB 1
`define RCW_WDCS_LSB 8
`define RCW_WIN_LSB 11
// Reset values and the software brown-out mode code
`define RCW_CAUSE_POR 8'h3C
`define RCW_WDPS_RST 5'h0B
`define RCW_WIN_RST 3'h7
`define RCW_BOR_MODE_SW 2'h1
// Watchdog mode codes
`define RCW_WD_OFF 2'h0
`define RCW_WD_SW 2'h1
`define RCW_WD_AWAKE 2'h2
`define RCW_WD_ON 2'h3
// Prescale limits and brown-out warm-up
`define RCW_WDPS_MAX 5'h12
`define RCW_BOR_WARM_US 10
`define RCW_CLK_MHZ 100
`define RCW_BOR_WARM_CYC (`RCW_BOR_WARM_US * `RCW_CLK_MHZ)
`endif

// ===== include/rcw_pkg.sv
package rcw_pkg;
  typedef enum logic [1:0] {
    RCW_IDLE,
    RCW_ACK
  } rcw_bus_type;

  typedef struct packed {
    logic stack_overflow;
    logic stack_underflow;
    logic wd_window_violation;
    logic wd_timeout;
    logic ext_reset_pin;
    logic reset_instr;
    logic power_on;
    logic brownout;
  } rcw_cause_type;

  typedef struct packed {
    logic [1:0] brownout_cfg_mode;
    logic [1:0] wd_mode_cfg;
    logic wd_cfg_clock_select;
  } rcw_cfg_type;
endpackage

// ===== tb/rcw_top_assertions.sv
`timescale 1ns/1ps
`include "rcw_cfg.svh"
// =========
// Port checker
module rcw_top_assertions
  import rcw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Straps and events
  input wire logic [1:0] brownout_cfg_mode,
  input wire logic [1:0] wd_mode_cfg,
  input wire logic wd_cfg_clock_select,
  input wire logic stack_overflow_event,
  input wire logic stack_underflow_event,
  input wire logic sleep,
  // Outputs
  input wire logic brownout_reset_enable,
  input wire logic wd_active,
  input wire logic wd_low_freq_osc_en,
  input wire logic wd_mid_freq_osc_en,
  input wire logic device_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic unmapped;
  assign unmapped = !(avs_address inside {`RCW_IDX_BORCTL, `RCW_IDX_CAUSE, `RCW_IDX_WDCTL,
    `RCW_IDX_WDSTAT});
  sequence take_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Reset level is part of each window so no attempt straddles a reset release
  sequence asleep_s;
    (rst_n && wd_mode_cfg == 2'h2 && sleep) [*4];
  endsequence
  sequence awake_s;
    (rst_n && wd_mode_cfg == 2'h2 && !sleep) [*4];
  endsequence
  bus_answer_a: assert property (take_s |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  unmapped_resp_a: assert property ((take_s and unmapped) |=>
    avs_response == 2'h2 && avs_readdata == 32'h0000_0000) else $error("unmapped answer wrong");
  bor_strap_a: assert property (rst_n && brownout_cfg_mode != 2'h1 |=>
    brownout_reset_enable == $past(brownout_cfg_mode[1])) else $error("brown-out enable wrong");
  wd_off_a: assert property (rst_n && wd_mode_cfg == 2'h0 |=> !wd_active)
    else $error("watchdog active in off mode");
  wd_on_a: assert property (rst_n && wd_mode_cfg == 2'h3 |=> wd_active)
    else $error("watchdog idle in always-on mode");
  sleep_off_a: assert property (asleep_s |=> !wd_active)
    else $error("watchdog active asleep");
  awake_on_a: assert property (awake_s |=> wd_active)
    else $error("watchdog idle while awake");
  osc_pick_a: assert property (rst_n && wd_mode_cfg == 2'h3 |=>
    wd_mid_freq_osc_en == wd_cfg_clock_select && wd_low_freq_osc_en == !wd_cfg_clock_select)
    else $error("oscillator choice wrong");
  stack_req_a: assert property ($rose(stack_overflow_event) || $rose(stack_underflow_event)
    |-> ##[2:6] device_reset_req) else $error("stack event without reset request");
  req_pulse_a: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset request longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    avs_waitrequest && !device_reset_req && !wd_active) else $error("outputs busy in reset");
endmodule

bind rcw_top rcw_top_assertions u_rcw_chk (.*);

// ===== tb/rcw_top_tb.sv
`timescale 1ns/1ps
`include "rcw_cfg.svh"
`define CHK(g, w) \
  compares++; \
  if ((g) !== (w)) begin \
    err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (g), (w)); \
  end
// =========
// Bench
module rcw_top_tb import rcw_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] addr = 14'h0000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h3;
  logic [31:0] avs_readdata, rd;
  logic [1:0] avs_response, rs;
  logic avs_waitrequest, bor_en, wd_active, lf_en, mf_en, rst_req;
  logic [1:0] bor_mode = 2'h1;
  logic [1:0] wd_mode = 2'h0;
  logic cfg_cs = 1'b0;
  logic [4:0] ev = 5'h00;
  logic bor_ready = 1'b0;
  logic sleep = 1'b0;
  logic wd_clr = 1'b0;
  logic osc = 1'b0;
  logic osc_run = 1'b0;
  int err_count = 0;
  int compares = 0;
  rcw_top dut (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .brownout_cfg_mode(bor_mode), .wd_mode_cfg(wd_mode), .wd_cfg_clock_select(cfg_cs),
    .brownout_event(ev[0]), .ext_reset_pin_event(ev[1]), .reset_instr_event(ev[2]),
    .stack_overflow_event(ev[3]), .stack_underflow_event(ev[4]),
    .brownout_circuit_ready(bor_ready), .sleep(sleep), .wd_clear_instr(wd_clr),
    .low_freq_osc(osc), .mid_freq_osc(osc), .brownout_reset_enable(bor_en),
    .wd_active(wd_active), .wd_low_freq_osc_en(lf_en), .wd_mid_freq_osc_en(mf_en),
    .device_reset_req(rst_req)
  );
  always #5 clk = ~clk;
  // Slow tick well below the sync rate so no edge is lost
  always begin
    repeat (3) @(posedge clk);
    if (osc_run) osc <= ~osc;
  end
  // =========
  // Bus and helper tasks
  task bus(input logic w, input logic [13:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    // Sampled right at the rising edge, before that edge's updates land
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    `CHK(avs_waitrequest, 1'b0)
    rd = avs_readdata;
    rs = avs_response;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task do_reset(input logic [1:0] wm, input logic [1:0] bm, input logic c);
    @(posedge clk);
    rst_n <= 1'b0;
    wd_mode <= wm;
    bor_mode <= bm;
    cfg_cs <= c;
    sleep <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Events are held past the three-flop synchroniser
  task evt(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
  endtask
  task wait_req;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (rst_req === 1'b1) break;
    end
    `CHK(rst_req, 1'b1)
  endtask
  // =========
  // Scenarios
  task t_reset;
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'h3C)
    bus(0, `RCW_IDX_BORCTL, 16'h0000);
    `CHK(rd[7:0], 8'h80)
    `CHK(bor_en, 1'b1)
    bor_ready <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, `RCW_IDX_BORCTL, 16'h0000);
    `CHK(rd[7:0], 8'h81)
    bus(1, `RCW_IDX_BORCTL, 16'h0000);
    bus(0, `RCW_IDX_BORCTL, 16'h0000);
    `CHK(rd[7:0], 8'h00)
    `CHK(bor_en, 1'b0)
  endtask
  task t_flags;
    bus(1, `RCW_IDX_CAUSE, 16'h0000);
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'h00)
    bus(1, `RCW_IDX_CAUSE, 16'h00FF);
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'hFF)
    evt(1);
    `CHK(rd[7:0], 8'hF7)
    evt(2);
    `CHK(rd[7:0], 8'hF3)
    bus(1, `RCW_IDX_CAUSE, 16'h0000);
    evt(3);
    `CHK(rd[7:0], 8'h80)
    evt(4);
    `CHK(rd[7:0], 8'hC0)
    bus(1, `RCW_IDX_CAUSE, 16'h00C2);
    evt(0);
    `CHK(rd[7:0], 8'h3E)
    bus(0, `RCW_IDX_BORCTL, 16'h0000);
    `CHK(rd[7:0], 8'h81)
    bus(0, 14'h0EE1, 16'h0000);
    `CHK({rs, rd[7:0]}, 10'h200)
    bus(1, 14'h0FD6, 16'h00FF);
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'h3E)
  endtask
  task t_modes;
    logic [1:0] m;
    for (int k = 0; k < 8; k++) begin
      m = k[2:1];
      do_reset(m, m, m[0]);
      sleep <= k[0];
      if (m == 2'h1) bus(1, `RCW_IDX_WDCTL, 16'h3901);
      repeat (6) @(posedge clk);
      `CHK(wd_active, m[0] | (m[1] & !k[0]))
      if (wd_active === 1'b1) begin `CHK({lf_en, mf_en}, {!m[0], m[0]}) end
      if (m != 2'h1) begin `CHK(bor_en, m[1]) end
    end
  endtask
  // Clear without an arming read is a violation, then the slow tick times out
  task t_wd;
    do_reset(2'h3, 2'h1, 1'b0);
    bus(1, `RCW_IDX_WDCTL, 16'h3800);
    wd_clr <= 1'b1;
    repeat (4) @(posedge clk);
    wd_clr <= 1'b0;
    wait_req;
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'h1C)
    osc_run <= 1'b1;
    wait_req;
    osc_run <= 1'b0;
    bus(0, `RCW_IDX_CAUSE, 16'h0000);
    `CHK(rd[7:0], 8'h0C)
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    do_reset(2'h0, 2'h1, 1'b0);
    t_reset;
    t_flags;
    t_modes;
    t_wd;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
endmodule
